// File: rtl/bla_params.svh
`ifndef BLA_PARAMS_SVH
`define BLA_PARAMS_SVH

// Register byte offsets
`define BLA_OFS_LOCK      8'h22
`define BLA_OFS_STAT      8'h26

// Lock register layout
`define BLA_LOCK_BIT      0
`define BLA_LOCK_RSV      15'h7fff

// Address and trigger status layout
`define BLA_TRIG_LSB      8
`define BLA_ADDR_LSB      0

// Byte lane of the lock flag
`define BLA_LANE_LOW      0

// Read data for an unmapped offset
`define BLA_UNMAPPED_RD   16'h0000

// Reset values
`define BLA_RDATA_RST     16'h0000
`define BLA_ACK_RST       1'h0

// Narrowest address that still reaches both offsets
`define BLA_MIN_ADDR_W    6

`endif

// File: rtl/bla_pkg.sv
package bla_pkg;

	// Lock channel states, Gray along idle -> arbitrate -> owned
	typedef enum logic [1:0]
	{
		BLA_IDLE  = 2'h0,
		BLA_ARB   = 2'h1,
		BLA_OWNED = 2'h3
	} bla_lock_st_t;

	typedef logic [15:0] bla_word_t;
	typedef logic [1:0]  bla_be_t;

endpackage

// File: rtl/bla_lock_if.sv
`timescale 1ns/1ps

interface bla_lock_if;
	logic set_req;
	logic clr_req;
	logic locked;

	modport ctl
	(
		output set_req,
		output clr_req,
		input  locked
	);

	modport chan
	(
		input  set_req,
		input  clr_req,
		output locked
	);
endinterface

// File: rtl/bla_lock_chan.sv
`timescale 1ns/1ps

module bla_lock_chan
(
	// Clock and resets
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic soft_rst,
	// Requests from the register side
	bla_lock_if.chan  lk,
	// Arbitration for the opposite bus
	output      logic bus_req,
	input  wire logic bus_gnt,
	output      logic bus_hold
);

	bla_pkg::bla_lock_st_t st_q;

	always_ff @(posedge mclk)
	begin
		if (srst || soft_rst)
		begin
			st_q <= bla_pkg::BLA_IDLE;
		end
		else
		begin
			unique case (st_q)
				bla_pkg::BLA_IDLE:
				begin
					if (lk.set_req)
					begin
						st_q <= bla_pkg::BLA_ARB;
					end
				end
				bla_pkg::BLA_ARB:
				begin
					// Abandon a pending lock as well as a won one
					if (lk.clr_req)
					begin
						st_q <= bla_pkg::BLA_IDLE;
					end
					else if (bus_gnt)
					begin
						st_q <= bla_pkg::BLA_OWNED;
					end
				end
				bla_pkg::BLA_OWNED:
				begin
					if (lk.clr_req)
					begin
						st_q <= bla_pkg::BLA_IDLE;
					end
				end
				default:
				begin
					st_q <= bla_pkg::BLA_IDLE;
				end
			endcase
		end
	end

	assign bus_req   = (st_q != bla_pkg::BLA_IDLE);
	assign bus_hold  = (st_q == bla_pkg::BLA_OWNED);
	assign lk.locked = (st_q == bla_pkg::BLA_OWNED);

endmodule

// File: rtl/bla_bus_lock.sv
// Summary of operation
// - The fifteen reserved upper bits of the lock register read back as ones.
// - A backplane-side write of one to the lock flag starts arbitration for the cable bus.
// - Once the cable bus is won under that lock it is held until cleared or reset.
// - A cable-side write of one to the lock flag acquires and holds the backplane bus.
// - Each side reads the lock state of the opposite bus, one meaning locked.
// - The lock flag reads zero after a write of one until the target bus is won.
// - Writing zero to the lock flag releases the bus locked through that side.
// - Hard and soft resets clear the lock flag and release any held bus.
// - The lock register takes 16-bit and single-byte reads and writes.
// - The upper byte of the status register shows the live TTL trigger lines.
// - The lower byte of the status register shows the own logical address.
// - The status register is read-only and takes 16-bit and single-byte reads.
`timescale 1ns/1ps
`include "bla_params.svh"

module bla_bus_lock
#(
	parameter int ADDR_W = 8
)
(
	// Clock and resets
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire logic                   soft_rst,
	// Register ports, index 0 backplane side, index 1 cable side
	input  wire logic [1:0][ADDR_W-1:0] reg_addr,
	input  wire logic [1:0]             reg_rd,
	input  wire logic [1:0]             reg_wr,
	input  wire logic [1:0][1:0]        reg_be,
	input  wire logic [1:0][15:0]       reg_wdata,
	output      logic [1:0][15:0]       reg_rdata,
	output      logic [1:0]             reg_ack,
	// Arbitration for the bus opposite each side
	output      logic [1:0]             lock_req,
	input  wire logic [1:0]             lock_gnt,
	output      logic [1:0]             lock_hold,
	// Live status inputs
	input  wire logic [7:0]             ttl_line_state,
	input  wire logic [7:0]             own_logical_address
);

	generate
		if (ADDR_W < `BLA_MIN_ADDR_W)
		begin : g_bad_addr
			$error("bla_bus_lock: ADDR_W too narrow for the register offsets");
		end
	endgenerate

	localparam logic [ADDR_W-1:0] OFS_LOCK = ADDR_W'(`BLA_OFS_LOCK);
	localparam logic [ADDR_W-1:0] OFS_STAT = ADDR_W'(`BLA_OFS_STAT);

	// Status word shared by both sides
	bla_pkg::bla_word_t stat_word;

	always_comb
	begin
		stat_word = `BLA_UNMAPPED_RD;
		stat_word[`BLA_TRIG_LSB +: 8] = ttl_line_state;
		stat_word[`BLA_ADDR_LSB +: 8] = own_logical_address;
	end

	genvar s;
	generate
		for (s = 0; s < 2; s++)
		begin : g_side
			bla_lock_if lk ();

			logic               hit_lock;
			logic               hit_stat;
			logic               wr_flag;
			bla_pkg::bla_word_t lock_word;
			bla_pkg::bla_word_t rd_word;
			bla_pkg::bla_word_t rdata_q;
			logic               ack_q;

			assign hit_lock = (reg_addr[s] == OFS_LOCK);
			assign hit_stat = (reg_addr[s] == OFS_STAT);

			// Flag lives in the low lane; an upper-byte write leaves it alone
			assign wr_flag = reg_wr[s] && hit_lock && reg_be[s][`BLA_LANE_LOW];

			// Reserved write bits are not looked at
			assign lk.set_req = wr_flag && reg_wdata[s][`BLA_LOCK_BIT];
			assign lk.clr_req = wr_flag && !reg_wdata[s][`BLA_LOCK_BIT];

			// Side s reads the lock it placed on the opposite bus
			assign lock_word = {`BLA_LOCK_RSV, lk.locked};

			always_comb
			begin
				rd_word = `BLA_UNMAPPED_RD;
				if (hit_lock)
				begin
					rd_word = lock_word;
				end
				else if (hit_stat)
				begin
					rd_word = stat_word;
				end
			end

			// Full word is returned; a byte reader takes its own lane
			always_ff @(posedge mclk)
			begin
				if (srst)
				begin
					rdata_q <= `BLA_RDATA_RST;
				end
				else if (reg_rd[s])
				begin
					rdata_q <= rd_word;
				end
			end

			// Every access is answered, including writes to the status word
			always_ff @(posedge mclk)
			begin
				if (srst)
				begin
					ack_q <= `BLA_ACK_RST;
				end
				else
				begin
					ack_q <= reg_rd[s] || reg_wr[s];
				end
			end

			// One driver per side keeps the shared output vectors clean
			assign reg_rdata[s] = rdata_q;
			assign reg_ack[s]   = ack_q;

			bla_lock_chan u_chan
			(
				.mclk     (mclk),
				.srst     (srst),
				.soft_rst (soft_rst),
				.lk       (lk),
				.bus_req  (lock_req[s]),
				.bus_gnt  (lock_gnt[s]),
				.bus_hold (lock_hold[s])
			);
		end
	endgenerate

endmodule

// File: tb/bla_bus_lock_sva.sv
`timescale 1ns/1ps
`include "bla_params.svh"
module bla_chk
#(
	parameter int ADDR_W = 8
)
(
	// Clock and resets
	input wire logic                   mclk,
	input wire logic                   srst,
	input wire logic                   soft_rst,
	// Register ports
	input wire logic [1:0][ADDR_W-1:0] reg_addr,
	input wire logic [1:0]             reg_rd,
	input wire logic [1:0]             reg_wr,
	input wire logic [1:0][1:0]        reg_be,
	input wire logic [1:0][15:0]       reg_wdata,
	input wire logic [1:0][15:0]       reg_rdata,
	input wire logic [1:0]             reg_ack,
	// Arbitration
	input wire logic [1:0]             lock_req,
	input wire logic [1:0]             lock_gnt,
	input wire logic [1:0]             lock_hold,
	// Live status
	input wire logic [7:0]             ttl_line_state,
	input wire logic [7:0]             own_logical_address
);
	localparam logic [ADDR_W-1:0] A_LOCK = ADDR_W'(`BLA_OFS_LOCK);
	localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`BLA_OFS_STAT);
	wire logic w0 = reg_wr[0] && reg_addr[0] == A_LOCK && reg_be[0][0];
	wire logic r0 = reg_rd[0] && reg_addr[0] == A_LOCK;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_ack_pulse: assert property (reg_rd[0] || reg_wr[0] |=> reg_ack[0])
		else $error("ack");
	a_rsv_ones: assert property (r0 |=> reg_rdata[0][15:1] == 15'h7fff)
		else $error("rsv");
	a_flag_read: assert property (r0 |=> reg_rdata[0][0] == $past(lock_hold[0]))
		else $error("flag");
	a_stat_read: assert property (reg_rd[1] && reg_addr[1] == A_STAT |=>
		reg_rdata[1] == {$past(ttl_line_state), $past(own_logical_address)}) else $error("stat");
	a_set_arb: assert property (w0 && reg_wdata[0][0] && !soft_rst |=> lock_req[0])
		else $error("set");
	a_clr_rel: assert property (w0 && !reg_wdata[0][0] |=> !lock_req[0] && !lock_hold[0])
		else $error("clr");
	a_soft_clr: assert property (soft_rst |=> lock_req == 2'h0 && lock_hold == 2'h0)
		else $error("soft");
	a_grant_win: assert property (lock_req[0] && lock_gnt[0] && !soft_rst && !reg_wr[0]
		|=> lock_hold[0]) else $error("win");
	a_hold_keep: assert property (lock_hold[1] && !soft_rst && !reg_wr[1] |=> lock_hold[1])
		else $error("keep");
	c_own0: cover property (lock_hold[0]);
	c_own1: cover property (lock_hold[1]);
	c_soft: cover property (soft_rst && lock_hold != 2'h0);
endmodule
bind bla_bus_lock bla_chk #(.ADDR_W(ADDR_W)) bla_chk_i (.*);

// File: tb/bla_arb_model.sv
`timescale 1ns/1ps
module bla_arb_model
(
	input  wire logic       mclk,
	input  wire logic [1:0] lock_req,
	input  wire logic       slow,
	output      logic [1:0] lock_gnt
);
	int cnt[2];
	// Grant is a one-cycle pulse, later when slow
	always_ff @(posedge mclk)
		for (int i = 0; i < 2; i++)
		begin
			cnt[i] <= lock_req[i] ? cnt[i] + 1 : 0;
			lock_gnt[i] <= lock_req[i] && cnt[i] == (slow ? 6 : 1);
		end
endmodule

// File: tb/tb_bla_bus_lock.sv
`timescale 1ns/1ps
module tb_bla_bus_lock;
	logic mclk = 0, srst = 1, soft_rst = 0, slow = 0;
	logic [1:0][7:0] reg_addr = '0;
	logic [1:0] reg_rd = '0, reg_wr = '0, reg_ack, lock_req, lock_gnt, lock_hold;
	logic [1:0][1:0] reg_be = '0;
	logic [1:0][15:0] reg_wdata = '0, reg_rdata;
	logic [7:0] ttl_line_state = '0, own_logical_address = '0;
	logic [15:0] r = 16'hce05;
	int error_cnt = 0, num_checks = 0, lk[2] = '{0, 0}, rq[2] = '{0, 0};
	always #12.5 mclk = ~mclk;
	bla_bus_lock bla_bus_lock_i (.*);
	bla_arb_model bla_arb_model_i (.mclk, .lock_req, .slow, .lock_gnt);
	task report_and_stop;
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic acc(input int s, input bit w, input logic [7:0] a, input logic [1:0] b,
		input logic [15:0] d);
		logic [15:0] e;
		logic [3:0]  q;
		e = a == 8'h22 ? {15'h7fff, lk[s][0]} : a == 8'h26 ?
			{ttl_line_state, own_logical_address} : 16'h0000;
		reg_addr[s] <= a;
		reg_be[s] <= b;
		reg_wdata[s] <= d;
		reg_rd[s] <= !w;
		reg_wr[s] <= w;
		@(posedge mclk);
		reg_rd[s] <= 1'h0;
		reg_wr[s] <= 1'h0;
		@(negedge mclk);
		num_checks++;
		if (reg_ack[s] !== 1'h1)
		begin
			$display("[ERR] reg_ack exp 1 got %b", reg_ack[s]);
			error_cnt++;
		end
		if (!w && reg_rdata[s] !== e)
		begin
			$display("[ERR] reg_rdata exp %h got %h", e, reg_rdata[s]);
			error_cnt++;
		end
		q = {rq[1][0], rq[0][0], lk[1][0], lk[0][0]};
		if ({lock_req, lock_hold} !== q)
		begin
			$display("[ERR] lock_req_hold exp %h got %h", q, {lock_req, lock_hold});
			error_cnt++;
		end
		@(posedge mclk);
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	initial
	begin
		repeat (20) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		for (int m = 0; m < 4; m++)
		begin
			slow <= m[1];
			rq[m % 2] = 1;
			acc(m % 2, 1, 8'h22, 2'h1, 16'h0001);
			if (m > 1) acc(m % 2, 0, 8'h22, 2'h3, 16'h0000);
			repeat (12) @(posedge mclk);
			lk[m % 2] = 1;
			acc(m % 2, 0, 8'h22, 2'h1, 16'h0000);
			acc(1 - m % 2, 0, 8'h22, 2'h2, 16'h0000);
			acc(m % 2, 1, 8'h22, 2'h2, 16'h0000);
			acc(m % 2, 0, 8'h22, 2'h3, 16'h0000);
			rq[m % 2] = 0;
			lk[m % 2] = 0;
			if (m < 2) acc(m % 2, 1, 8'h22, 2'h3, 16'h0000);
			else
			begin
				soft_rst <= 1'h1;
				@(posedge mclk);
				soft_rst <= 1'h0;
			end
			acc(m % 2, 0, 8'h22, 2'h3, 16'h0000);
		end
		for (int i = 0; i < 6; i++)
		begin
			r = lfsr(r);
			ttl_line_state <= r[15:8];
			own_logical_address <= r[7:0];
			@(posedge mclk);
			acc(i % 2, 0, 8'h26, r[1:0], 16'h0000);
			acc(i % 2, 1, 8'h26, 2'h3, ~r);
			acc(i % 2, 0, 8'h26, 2'h1, 16'h0000);
		end
		acc(0, 0, 8'h30, 2'h3, 16'h0000);
		report_and_stop;
	end
endmodule
